// File: esc_defs.svh
// Purpose: offsets, field positions, reset values for the edge source select block
// Assumes: avalon-mm word addressing, 16-bit registers in the low lanes
// Notes: definitions only
`ifndef ESC_DEFS_SVH
`define ESC_DEFS_SVH
`define ESC_ADDR_W         4
`define ESC_OFF_CTRL2      4'h0
`define ESC_OFF_ICTRL      4'h1
`define ESC_OFF_STATUS     4'h2
`define ESC_SENS_BIT       7
`define ESC_POL_BIT        6
`define ESC_SEL_HI         5
`define ESC_SEL_LO         2
`define ESC_TRIM_HI        15
`define ESC_TRIM_LO        10
`define ESC_RNG_HI         9
`define ESC_RNG_LO         8
`define ESC_CTRL2_RST      16'h0000
`define ESC_ICTRL_RST      16'h0000
`define ESC_CTRL2_MASK     16'h00fc
`define ESC_ICTRL_MASK     16'hff00
`define ESC_ST_EDGE2_BIT   1
`define ESC_ST_EDGE1_BIT   0
`endif

// File: esc_edge_source_select.sv
// Purpose: second-edge control of a charge-time measurement unit: source select,
//          polarity, sensitivity, edge status, current trim and range registers
// Assumes: inputs synchronous to clock; avalon-mm slave with one wait cycle
// Notes: pin-count variant set by parameter PIN_VARIANT (0 full, 1 reduced, 2 smallest)
// Contract
// - sensitivity bit one means transitions only, zero means the level is used.
// - polarity bit one selects rising edge or high level, zero falling or low.
// - selector codes 1111, 1110, 1101 pick comparator three, two and one.
// - selector codes 1011, 1010, 1001 pick input capture three, two and one.
// - codes 1000 to 0010 pick external pins 13, 12, 11, 10, 9, 1 and 2.
// - code 0001 picks output compare one.
// - code 0000 picks the first timer output.
// - the two low bits of edge control two have no storage and read zero.
// - reduced variants lack pins 11 and 12; the smallest also lacks 3 and 13.
// - range 11 gives hundred times and 10 ten times the base current.
// - trim is two's complement around nominal at 000000.
// - edge status bits set when an edge occurs and may be written by software.
`timescale 1ns/1ps
`default_nettype none
`include "esc_defs.svh"
module esc_edge_source_select #(
  parameter int PIN_VARIANT = 0
) (
  input  wire logic                   clock,              // 200 mhz system clock
  input  wire logic                   arst_n,             // async reset, active low
  input  wire logic                   clk_en,             // freezes all state when low
  input  wire logic [`ESC_ADDR_W-1:0] avs_address,        // word address
  input  wire logic                   avs_read,           // read request
  input  wire logic                   avs_write,          // write request
  input  wire logic [31:0]            avs_writedata,      // write data
  input  wire logic [3:0]             avs_byteenable,     // byte lanes
  output logic [31:0]                 avs_readdata,       // read data, registered
  output logic                        avs_waitrequest,    // stall
  input  wire esc_pkg::esc_sources_s  sources,            // candidate edge sources
  input  wire logic                   first_edge_event,   // first-edge detector pulse
  output logic                        second_edge_in,     // selected, conditioned input
  output logic                        second_edge_status, // edge two has occurred
  output logic                        first_edge_status,  // edge one has occurred
  output esc_pkg::esc_current_s       current_cfg         // trim and range to analog
);

  // registers
  logic [15:0] ctrl2_ff, nxt_ctrl2;
  logic [15:0] ictrl_ff, nxt_ictrl;
  logic        st2_ff, nxt_st2;
  logic        st1_ff, nxt_st1;
  logic        src_ff, nxt_src;
  logic        lvl_ff, nxt_lvl;
  logic [31:0] rdata_ff, nxt_rdata;
  esc_pkg::esc_bus_e bus_ff, nxt_bus;

  logic       sens;
  logic       pol;
  logic [3:0] sel;
  logic       raw_src;
  logic       hit;
  logic       wr_go;
  logic       rd_go;
  logic [31:0] wmask;

  assign sens = ctrl2_ff[`ESC_SENS_BIT];
  assign pol  = ctrl2_ff[`ESC_POL_BIT];
  assign sel  = ctrl2_ff[`ESC_SEL_HI:`ESC_SEL_LO];

  // pin presence per variant; absent pins read as never active
  function automatic logic pin_present(input int pin);
    if (PIN_VARIANT >= 1 && (pin == 11 || pin == 12)) begin
      return 1'b0;
    end
    if (PIN_VARIANT >= 2 && (pin == 3 || pin == 13)) begin
      return 1'b0;
    end
    return 1'b1;
  endfunction

  // source multiplexer
  always_comb begin
    case (esc_pkg::esc_src_e'(sel))
      esc_pkg::ESC_SRC_CMP3:   raw_src = sources.comparator[2];
      esc_pkg::ESC_SRC_CMP2:   raw_src = sources.comparator[1];
      esc_pkg::ESC_SRC_CMP1:   raw_src = sources.comparator[0];
      esc_pkg::ESC_SRC_IC3:    raw_src = sources.input_capture[2];
      esc_pkg::ESC_SRC_IC2:    raw_src = sources.input_capture[1];
      esc_pkg::ESC_SRC_IC1:    raw_src = sources.input_capture[0];
      esc_pkg::ESC_SRC_PIN13:  raw_src = sources.external_edge_pin[13] & pin_present(13);
      esc_pkg::ESC_SRC_PIN12:  raw_src = sources.external_edge_pin[12] & pin_present(12);
      esc_pkg::ESC_SRC_PIN11:  raw_src = sources.external_edge_pin[11] & pin_present(11);
      esc_pkg::ESC_SRC_PIN10:  raw_src = sources.external_edge_pin[10];
      esc_pkg::ESC_SRC_PIN9:   raw_src = sources.external_edge_pin[9];
      esc_pkg::ESC_SRC_PIN1:   raw_src = sources.external_edge_pin[1];
      esc_pkg::ESC_SRC_PIN2:   raw_src = sources.external_edge_pin[2];
      esc_pkg::ESC_SRC_OC1:    raw_src = sources.output_compare_one;
      esc_pkg::ESC_SRC_FIRST_TIMER: raw_src = sources.first_timer;
      default:                 raw_src = 1'b0; // code 1100 has no source
    endcase
  end

  // polarity and sensitivity: edge mode needs a change, level mode the active level
  always_comb begin
    nxt_src = raw_src;
    nxt_lvl = (raw_src == pol);
    // edge mode: a change into the active level, even if polarity moved in the same cycle
    if (sens) begin
      hit = nxt_lvl & (raw_src != src_ff);
    end else begin
      hit = nxt_lvl;
    end
  end

  // bus decode
  assign wr_go = avs_write && (bus_ff == esc_pkg::ESC_BUS_ACK);
  assign rd_go = avs_read && (bus_ff == esc_pkg::ESC_BUS_ACK);
  // a frozen clock cannot take the request, so the stall must hold too
  assign avs_waitrequest = (avs_read || avs_write) &&
                           (bus_ff != esc_pkg::ESC_BUS_ACK || !clk_en);
  assign wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                  {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

  // next register values; hardware set wins over software clear
  always_comb begin
    logic [15:0] wd;
    wd        = avs_writedata[15:0] & wmask[15:0];
    nxt_ctrl2 = ctrl2_ff;
    nxt_ictrl = ictrl_ff;
    nxt_st2   = st2_ff;
    nxt_st1   = st1_ff;
    nxt_bus   = esc_pkg::ESC_BUS_IDLE;
    nxt_rdata = rdata_ff;
    if ((avs_read || avs_write) && bus_ff == esc_pkg::ESC_BUS_IDLE) begin
      nxt_bus = esc_pkg::ESC_BUS_ACK; // one wait cycle
      case (avs_address)
        `ESC_OFF_CTRL2:  nxt_rdata = {16'h0000, ctrl2_ff};
        `ESC_OFF_ICTRL:  nxt_rdata = {16'h0000, ictrl_ff};
        `ESC_OFF_STATUS: nxt_rdata = {30'h0, st2_ff, st1_ff};
        default:         nxt_rdata = 32'h00000000;
      endcase
    end
    if (wr_go) begin
      case (avs_address)
        `ESC_OFF_CTRL2: begin
          nxt_ctrl2 = (ctrl2_ff & ~wmask[15:0]) | (wd & `ESC_CTRL2_MASK);
        end
        `ESC_OFF_ICTRL: begin
          nxt_ictrl = (ictrl_ff & ~wmask[15:0]) | (wd & `ESC_ICTRL_MASK);
        end
        `ESC_OFF_STATUS: begin
          if (avs_byteenable[0]) begin
            nxt_st2 = avs_writedata[`ESC_ST_EDGE2_BIT];
            nxt_st1 = avs_writedata[`ESC_ST_EDGE1_BIT];
          end
        end
        default: begin
          nxt_ctrl2 = ctrl2_ff;
        end
      endcase
    end
    if (hit) begin
      nxt_st2 = 1'b1;
    end
    if (first_edge_event) begin
      nxt_st1 = 1'b1;
    end
  end

  // state registers, frozen while clk_en is low
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ctrl2_ff <= `ESC_CTRL2_RST;
      ictrl_ff <= `ESC_ICTRL_RST;
      st2_ff   <= 1'b0;
      st1_ff   <= 1'b0;
      src_ff   <= 1'b0;
      lvl_ff   <= 1'b0;
      rdata_ff <= 32'h00000000;
      bus_ff   <= esc_pkg::ESC_BUS_IDLE;
    end else if (clk_en) begin
      ctrl2_ff <= nxt_ctrl2;
      ictrl_ff <= nxt_ictrl;
      st2_ff   <= nxt_st2;
      st1_ff   <= nxt_st1;
      src_ff   <= nxt_src;
      lvl_ff   <= nxt_lvl;
      rdata_ff <= nxt_rdata;
      bus_ff   <= nxt_bus;
    end
  end

  assign avs_readdata       = rdata_ff;
  assign second_edge_in     = lvl_ff;
  assign second_edge_status = st2_ff;
  assign first_edge_status  = st1_ff;
  // range 11 = x100, 10 = x10 base; trim signed, passed raw to the analog trim
  assign current_cfg.current_trim  = ictrl_ff[`ESC_TRIM_HI:`ESC_TRIM_LO];
  assign current_cfg.current_range = ictrl_ff[`ESC_RNG_HI:`ESC_RNG_LO];

  // checks
  sens_edge_a: assert property (@(posedge clock) disable iff (!arst_n)
    clk_en && sens && raw_src == src_ff && !st2_ff && !wr_go |=> !st2_ff)
    else $error("edge mode set on steady level");
  level_set_a: assert property (@(posedge clock) disable iff (!arst_n)
    clk_en && !sens && raw_src == pol |=> st2_ff)
    else $error("level mode did not set status");
  pol_edge_a: assert property (@(posedge clock) disable iff (!arst_n)
    clk_en && sens && pol && raw_src && !src_ff |=> st2_ff)
    else $error("rising edge missed");
  cmp3_sel_a: assert property (@(posedge clock) disable iff (!arst_n)
    sel == 4'hf |-> raw_src == sources.comparator[2])
    else $error("comparator three not routed");
  ic1_sel_a: assert property (@(posedge clock) disable iff (!arst_n)
    sel == 4'h9 |-> raw_src == sources.input_capture[0])
    else $error("capture one not routed");
  pin1_sel_a: assert property (@(posedge clock) disable iff (!arst_n)
    sel == 4'h3 |-> raw_src == sources.external_edge_pin[1])
    else $error("pin one not routed");
  oc_sel_a: assert property (@(posedge clock) disable iff (!arst_n)
    sel == 4'h1 |-> raw_src == sources.output_compare_one)
    else $error("compare one not routed");
  timer_sel_a: assert property (@(posedge clock) disable iff (!arst_n)
    sel == 4'h0 |-> raw_src == sources.first_timer)
    else $error("timer not routed");
  low_bits_a: assert property (@(posedge clock) disable iff (!arst_n)
    ctrl2_ff[1:0] == 2'b00 && ictrl_ff[7:0] == 8'h00)
    else $error("unimplemented bits hold data");
  first_set_a: assert property (@(posedge clock) disable iff (!arst_n)
    clk_en && first_edge_event |=> first_edge_status)
    else $error("first edge status not set");
  wait_one_a: assert property (@(posedge clock) disable iff (!arst_n)
    clk_en && avs_read && !avs_waitrequest |=> avs_waitrequest || !avs_read)
    else $error("bus answered twice");

  // routing of the remaining selector codes
  cmp2_sel_a: assert property (@(posedge clock) disable iff (!arst_n)
    sel == 4'he |-> raw_src == sources.comparator[1])
    else $error("comparator two not routed");
  cmp1_sel_a: assert property (@(posedge clock) disable iff (!arst_n)
    sel == 4'hd |-> raw_src == sources.comparator[0])
    else $error("comparator one not routed");
  ic3_sel_a: assert property (@(posedge clock) disable iff (!arst_n)
    sel == 4'hb |-> raw_src == sources.input_capture[2])
    else $error("capture three not routed");
  ic2_sel_a: assert property (@(posedge clock) disable iff (!arst_n)
    sel == 4'ha |-> raw_src == sources.input_capture[1])
    else $error("capture two not routed");
  pin2_sel_a: assert property (@(posedge clock) disable iff (!arst_n)
    sel == 4'h2 |-> raw_src == sources.external_edge_pin[2])
    else $error("pin two not routed");
  pin9_sel_a: assert property (@(posedge clock) disable iff (!arst_n)
    sel == 4'h4 |-> raw_src == sources.external_edge_pin[9])
    else $error("pin nine not routed");
  pin10_sel_a: assert property (@(posedge clock) disable iff (!arst_n)
    sel == 4'h5 |-> raw_src == sources.external_edge_pin[10])
    else $error("pin ten not routed");
  pin11_sel_a: assert property (@(posedge clock) disable iff (!arst_n)
    PIN_VARIANT == 0 && sel == 4'h6 |-> raw_src == sources.external_edge_pin[11])
    else $error("pin eleven not routed");
  pin12_sel_a: assert property (@(posedge clock) disable iff (!arst_n)
    PIN_VARIANT == 0 && sel == 4'h7 |-> raw_src == sources.external_edge_pin[12])
    else $error("pin twelve not routed");
  pin13_sel_a: assert property (@(posedge clock) disable iff (!arst_n)
    PIN_VARIANT < 2 && sel == 4'h8 |-> raw_src == sources.external_edge_pin[13])
    else $error("pin thirteen not routed");

  // absent pins on smaller variants and the reserved code 1100 must never look active
  pin11_gone_a: assert property (@(posedge clock) disable iff (!arst_n)
    PIN_VARIANT >= 1 && sel == 4'h6 |-> !raw_src)
    else $error("absent pin eleven seen");
  pin12_gone_a: assert property (@(posedge clock) disable iff (!arst_n)
    PIN_VARIANT >= 1 && sel == 4'h7 |-> !raw_src)
    else $error("absent pin twelve seen");
  pin13_gone_a: assert property (@(posedge clock) disable iff (!arst_n)
    PIN_VARIANT >= 2 && sel == 4'h8 |-> !raw_src)
    else $error("absent pin thirteen seen");
  none_sel_a: assert property (@(posedge clock) disable iff (!arst_n)
    sel == 4'hc |-> !raw_src)
    else $error("reserved code drives a source");

  // polarity, conditioned output, sticky status, freeze and current fields
  pol_fall_a: assert property (@(posedge clock) disable iff (!arst_n)
    clk_en && sens && !pol && !raw_src && src_ff |=> st2_ff)
    else $error("falling edge missed");
  level_track_a: assert property (@(posedge clock) disable iff (!arst_n)
    clk_en |=> second_edge_in == $past(nxt_lvl))
    else $error("conditioned input lags");
  edge_set_a: assert property (@(posedge clock) disable iff (!arst_n)
    clk_en && hit |=> second_edge_status)
    else $error("second edge status not set");
  st2_hold_a: assert property (@(posedge clock) disable iff (!arst_n)
    clk_en && st2_ff && !wr_go |=> st2_ff)
    else $error("second edge status lost");
  st1_hold_a: assert property (@(posedge clock) disable iff (!arst_n)
    clk_en && st1_ff && !wr_go |=> st1_ff)
    else $error("first edge status lost");
  freeze_a: assert property (@(posedge clock) disable iff (!arst_n)
    !clk_en |=> $stable(ctrl2_ff) && $stable(ictrl_ff) && $stable(st2_ff) && $stable(st1_ff))
    else $error("state moved while frozen");
  rng_out_a: assert property (@(posedge clock) disable iff (!arst_n)
    current_cfg.current_range == ictrl_ff[9:8])
    else $error("range field not passed on");
  trim_out_a: assert property (@(posedge clock) disable iff (!arst_n)
    current_cfg.current_trim == ictrl_ff[15:10])
    else $error("trim field not passed on");

  // register read-back and bus timing
  rd_ctrl2_a: assert property (@(posedge clock) disable iff (!arst_n)
    rd_go && avs_address == `ESC_OFF_CTRL2 |-> avs_readdata[1:0] == 2'b00 &&
    avs_readdata[31:8] == 24'h0)
    else $error("control two spare bits read set");
  wr_ctrl2_a: assert property (@(posedge clock) disable iff (!arst_n)
    clk_en && wr_go && avs_address == `ESC_OFF_CTRL2 |=> ctrl2_ff[1:0] == 2'b00)
    else $error("control two low bits stored");
  rd_ictrl_a: assert property (@(posedge clock) disable iff (!arst_n)
    rd_go && avs_address == `ESC_OFF_ICTRL |-> avs_readdata[7:0] == 8'h00 &&
    avs_readdata[31:16] == 16'h0)
    else $error("current control low byte read set");
  rd_status_a: assert property (@(posedge clock) disable iff (!arst_n)
    rd_go && avs_address == `ESC_OFF_STATUS |-> avs_readdata[31:2] == 30'h0)
    else $error("status spare bits read set");
  rd_unmapped_a: assert property (@(posedge clock) disable iff (!arst_n)
    rd_go && avs_address > `ESC_OFF_STATUS |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  wr_unmapped_a: assert property (@(posedge clock) disable iff (!arst_n)
    clk_en && wr_go && avs_address > `ESC_OFF_STATUS |=> $stable(ctrl2_ff) && $stable(ictrl_ff))
    else $error("unmapped write changed state");
  first_wait_a: assert property (@(posedge clock) disable iff (!arst_n)
    (avs_read || avs_write) && bus_ff == esc_pkg::ESC_BUS_IDLE |-> avs_waitrequest)
    else $error("request answered without wait");
  idle_stall_a: assert property (@(posedge clock) disable iff (!arst_n)
    !avs_read && !avs_write |-> !avs_waitrequest)
    else $error("stall with no request");
  ack_once_a: assert property (@(posedge clock) disable iff (!arst_n)
    clk_en && bus_ff == esc_pkg::ESC_BUS_ACK |=> bus_ff == esc_pkg::ESC_BUS_IDLE)
    else $error("acknowledge held too long");
  frozen_stall_a: assert property (@(posedge clock) disable iff (!arst_n)
    !clk_en && (avs_read || avs_write) |-> avs_waitrequest)
    else $error("request answered while frozen");

  // main scenarios
  edge_hit_c: cover property (@(posedge clock) disable iff (!arst_n) sens && hit);
  level_hit_c: cover property (@(posedge clock) disable iff (!arst_n) !sens && hit);
  wr_ictrl_c: cover property (@(posedge clock) disable iff (!arst_n)
    wr_go && avs_address == `ESC_OFF_ICTRL);
  rd_status_c: cover property (@(posedge clock) disable iff (!arst_n)
    rd_go && avs_address == `ESC_OFF_STATUS);
  fall_hit_c: cover property (@(posedge clock) disable iff (!arst_n) sens && !pol && hit);

endmodule
`default_nettype wire

// File: esc_edge_source_select_test.sv
// Purpose: self-checking bench for the second-edge source select block
// Assumes: one wait cycle per bus request, registered edge outputs
// Notes: full pin variant only; clk_en held high and all byte lanes enabled
`timescale 1ns/1ps
`default_nettype none
module esc_edge_source_select_test;
  logic                  clock            = 1'b0;
  logic                  arst_n           = 1'b0;
  logic [3:0]            avs_address      = 4'h0;
  logic                  avs_read         = 1'b0;
  logic                  avs_write        = 1'b0;
  logic [31:0]           avs_writedata    = 32'h0;
  logic [31:0]           avs_readdata;
  logic                  avs_waitrequest;
  logic                  second_edge_in;
  logic                  second_edge_status;
  logic                  first_edge_status;
  logic                  first_edge_event = 1'b0;
  esc_pkg::esc_sources_s sources          = '0;
  esc_pkg::esc_current_s current_cfg;
  logic [31:0]           rd;
  int                    mismatches       = 0;
  int                    check_count      = 0;
  int                    pin_tab [7]      = '{2, 1, 9, 10, 11, 12, 13};

  // 200 mhz clock
  always #2.5 clock = ~clock;

  esc_edge_source_select esc_edge_source_select_i (
    .clock              (clock),
    .arst_n             (arst_n),
    .clk_en             (1'b1),
    .avs_address        (avs_address),
    .avs_read           (avs_read),
    .avs_write          (avs_write),
    .avs_writedata      (avs_writedata),
    .avs_byteenable     (4'hf),
    .avs_readdata       (avs_readdata),
    .avs_waitrequest    (avs_waitrequest),
    .sources            (sources),
    .first_edge_event   (first_edge_event),
    .second_edge_in     (second_edge_in),
    .second_edge_status (second_edge_status),
    .first_edge_status  (first_edge_status),
    .current_cfg        (current_cfg)
  );

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // one avalon request, held until waitrequest is sampled low at a rising
  // edge; data is taken and the request dropped at that edge; a hang is
  // left to the watchdog
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= ~wr;
    do begin
      @(posedge clock);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic rchk(input logic [3:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  // new source vector, then two edges for the registered outputs to follow
  task automatic drive(input esc_pkg::esc_sources_s s);
    @(posedge clock);
    sources <= s;
    repeat (2) @(posedge clock);
    @(negedge clock);
  endtask

  // expected routing: exactly the one source that a code names
  function automatic esc_pkg::esc_sources_s one_src(input logic [3:0] c);
    esc_pkg::esc_sources_s s;
    s = '0;
    if (c >= 4'hd) s.comparator[c - 4'hd] = 1'b1;
    else if (c >= 4'h9 && c <= 4'hb) s.input_capture[c - 4'h9] = 1'b1;
    else if (c >= 4'h2 && c <= 4'h8) s.external_edge_pin[pin_tab[c - 4'h2]] = 1'b1;
    else if (c == 4'h1) s.output_compare_one = 1'b1;
    else s.first_timer = 1'b1;
    return s;
  endfunction

  // watchdog well beyond the few hundred cycles the sequence needs
  initial begin
    #100000;
    mismatches++;
    wrap_up();
  end

  initial begin
    repeat (20) @(posedge clock);
    arst_n <= 1'b1;
    chk({24'h0, current_cfg}, 32'h0);
    rchk(4'h0, 32'h0);
    rchk(4'h1, 32'h0);
    bus(1'b1, 4'h0, 32'h0000ffff);
    rchk(4'h0, 32'h000000fc);
    bus(1'b1, 4'h1, 32'h0000ffff);
    rchk(4'h1, 32'h0000ff00);
    chk({24'h0, current_cfg}, 32'hff);
    bus(1'b1, 4'h1, 32'h00008500);
    @(negedge clock);
    chk({24'h0, current_cfg}, 32'h85);
    bus(1'b1, 4'h1, 32'h00000600);
    rchk(4'h1, 32'h00000600);
    chk({24'h0, current_cfg}, 32'h06);
    bus(1'b1, 4'h3, 32'h0000ffff);
    rchk(4'h3, 32'h0);
    // every selector code in level mode; the reserved code is never written
    for (int c = 0; c < 16; c++) begin
      if (c == 12) continue;
      bus(1'b1, 4'h0, {24'h0, 2'b01, 4'(c), 2'b00});
      drive(one_src(4'(c)));
      chk({31'h0, second_edge_in}, 32'h1);
      drive(~one_src(4'(c)));
      chk({31'h0, second_edge_in}, 32'h0);
      bus(1'b1, 4'h0, {24'h0, 2'b00, 4'(c), 2'b00});
      drive(~one_src(4'(c)));
      chk({31'h0, second_edge_in}, 32'h1);
    end
    // edge mode on the timer source: steady levels must not set status
    bus(1'b1, 4'h0, 32'h000000c0);
    drive('0);
    bus(1'b1, 4'h2, 32'h0);
    rchk(4'h2, 32'h0);
    drive(one_src(4'h0));
    rchk(4'h2, 32'h2);
    chk({31'h0, second_edge_status}, 32'h1);
    bus(1'b1, 4'h2, 32'h0);
    drive(one_src(4'h0));
    rchk(4'h2, 32'h0);
    bus(1'b1, 4'h0, 32'h00000040);
    drive(one_src(4'h0));
    rchk(4'h2, 32'h2);
    // falling edge selected by polarity zero
    bus(1'b1, 4'h0, 32'h00000080);
    bus(1'b1, 4'h2, 32'h0);
    rchk(4'h2, 32'h0);
    drive('0);
    rchk(4'h2, 32'h2);
    bus(1'b1, 4'h2, 32'h0);
    bus(1'b1, 4'h2, 32'h3);
    rchk(4'h2, 32'h3);
    chk({31'h0, first_edge_status}, 32'h1);
    bus(1'b1, 4'h2, 32'h0);
    @(posedge clock);
    first_edge_event <= 1'b1;
    @(posedge clock);
    first_edge_event <= 1'b0;
    rchk(4'h2, 32'h1);
    wrap_up();
  end
endmodule
`default_nettype wire

// File: esc_pkg.sv
// Purpose: types for the edge source select block
// Assumes: nothing
// Notes: source codes follow the selector encoding
package esc_pkg;
  typedef enum logic [3:0] {
    ESC_SRC_FIRST_TIMER = 4'b0000,
    ESC_SRC_OC1    = 4'b0001,
    ESC_SRC_PIN2   = 4'b0010,
    ESC_SRC_PIN1   = 4'b0011,
    ESC_SRC_PIN9   = 4'b0100,
    ESC_SRC_PIN10  = 4'b0101,
    ESC_SRC_PIN11  = 4'b0110,
    ESC_SRC_PIN12  = 4'b0111,
    ESC_SRC_PIN13  = 4'b1000,
    ESC_SRC_IC1    = 4'b1001,
    ESC_SRC_IC2    = 4'b1010,
    ESC_SRC_IC3    = 4'b1011,
    ESC_SRC_NONE   = 4'b1100,
    ESC_SRC_CMP1   = 4'b1101,
    ESC_SRC_CMP2   = 4'b1110,
    ESC_SRC_CMP3   = 4'b1111
  } esc_src_e;
  typedef struct packed {
    logic [2:0] comparator;          // bit0 = comparator one
    logic [2:0] input_capture;       // bit0 = channel one
    logic [13:1] external_edge_pin;  // pin n at index n
    logic       output_compare_one;
    logic       first_timer;
  } esc_sources_s;
  typedef struct packed {
    logic [5:0] current_trim;
    logic [1:0] current_range;
  } esc_current_s;
  typedef enum logic [1:0] {
    ESC_BUS_IDLE = 2'b00,
    ESC_BUS_ACK  = 2'b01
  } esc_bus_e;
endpackage
